// File: shared/ccfd_pkg.sv
// Purpose: constants for the channel configuration field decoder
// Assumes: 32-bit APB, word-aligned registers, byte address = index * 4
// Notes: field positions and reset values of the per-channel word
package ccfd_pkg;
   localparam int CCFD_CHANNELS = 16;
   localparam int CCFD_CFG_W = 24;
   localparam int CCFD_ADDR_W = 8;
   // register indices
   localparam logic [7:0] CCFD_CHAN_FIRST_IDX = 8'h09;
   localparam logic [7:0] CCFD_CHAN_LAST_IDX = 8'h18;
   localparam logic [7:0] CCFD_CTRL_IDX = 8'h20;
   localparam logic [7:0] CCFD_THR_LOW_IDX = 8'h21;
   localparam logic [7:0] CCFD_THR_HIGH_IDX = 8'h22;
   localparam logic [7:0] CCFD_STATUS_IDX = 8'h23;
   // channel word fields
   localparam int CCFD_ENABLE_BIT = 23;
   localparam int CCFD_SETUP_LSB = 20;
   localparam int CCFD_SETUP_W = 3;
   localparam int CCFD_SWITCH_BIT = 19;
   localparam int CCFD_THR_EN_BIT = 18;
   localparam int CCFD_POS_LSB = 13;
   localparam int CCFD_NEG_LSB = 8;
   localparam int CCFD_SEL_W = 5;
   localparam logic [23:0] CCFD_CHAN0_RESET = 24'h800100;
   localparam logic [23:0] CCFD_CHAN_RESET = 24'h000100;
   // control register fields
   localparam int CCFD_MODE_LSB = 0;
   localparam int CCFD_STBY_SW_BIT = 2;
   localparam int CCFD_BUF_EN_BIT = 3;
   localparam logic [1:0] CCFD_MODE_ACTIVE = 2'h0;
   localparam logic [1:0] CCFD_MODE_STANDBY = 2'h1;
   localparam logic [1:0] CCFD_MODE_POWER_DOWN = 2'h2;
   localparam logic [3:0] CCFD_CTRL_RESET = 4'h0;
   // input select codes
   localparam logic [4:0] CCFD_SEL_TEMP = 5'h10;
   localparam logic [4:0] CCFD_SEL_NEG_RAIL = 5'h11;
   localparam logic [4:0] CCFD_SEL_REF = 5'h12;
   localparam logic [4:0] CCFD_SEL_DIG_GND = 5'h13;
   localparam logic [4:0] CCFD_SEL_AVDD_P = 5'h14;
   localparam logic [4:0] CCFD_SEL_AVDD_M = 5'h15;
   localparam logic [4:0] CCFD_SEL_IO_P = 5'h16;
   localparam logic [4:0] CCFD_SEL_IO_M = 5'h17;
   localparam logic [4:0] CCFD_SEL_AREG_P = 5'h18;
   localparam logic [4:0] CCFD_SEL_AREG_M = 5'h19;
   localparam logic [4:0] CCFD_SEL_DREG_P = 5'h1A;
   localparam logic [4:0] CCFD_SEL_DREG_M = 5'h1B;
   localparam logic [4:0] CCFD_SEL_MV_P = 5'h1C;
   localparam logic [4:0] CCFD_SEL_MV_M = 5'h1D;
   typedef enum logic [3:0] {
      CCFD_SRC_EXTERNAL, CCFD_SRC_TEMP, CCFD_SRC_NEG_RAIL, CCFD_SRC_REF,
      CCFD_SRC_DIG_GND, CCFD_SRC_AVDD_P, CCFD_SRC_AVDD_M, CCFD_SRC_IO_P,
      CCFD_SRC_IO_M, CCFD_SRC_AREG_P, CCFD_SRC_AREG_M, CCFD_SRC_DREG_P,
      CCFD_SRC_DREG_M, CCFD_SRC_MV_P, CCFD_SRC_MV_M, CCFD_SRC_RESERVED
   } ccfd_src_e;
endpackage

// File: rtl/ccfd_chan_mem.sv
// Purpose: per-channel configuration store, one write and two read ports
// Assumes: read data registered, valid one edge after the address
// Notes: reset values differ only for channel 0
`timescale 1ns/100ps
`default_nettype none
module ccfd_chan_mem
   import ccfd_pkg::*;
#(
   parameter int DEPTH = CCFD_CHANNELS,
   parameter int WIDTH = CCFD_CFG_W
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write port
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // read ports
   input wire logic [$clog2(DEPTH)-1:0] rd_addr_a,
   output logic [WIDTH-1:0] rd_data_a,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr_b,
   output logic [WIDTH-1:0] rd_data_b
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_rd_data_a;
   logic [WIDTH-1:0] next_rd_data_b;

   always_comb begin
      next_rd_data_a = mem[rd_addr_a];
      next_rd_data_b = mem[rd_addr_b];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data_a <= '0;
         rd_data_b <= '0;
      end else begin
         rd_data_a <= next_rd_data_a;
         rd_data_b <= next_rd_data_b;
      end
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_word
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mem[g] <= (g == 0) ? WIDTH'(CCFD_CHAN0_RESET) : WIDTH'(CCFD_CHAN_RESET);
            end else if (wr_en && (wr_addr == g)) begin
               mem[g] <= wr_data;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// File: rtl/ccfd_top.sv
// Purpose: per-channel configuration registers and field decode
// Assumes: sequencer gives a one-cycle conv_start with conv_channel
// Notes: fields are latched per conversion; mode gating is live
// Operation
// R1: setup-select 6 or 7 picks setup register set 6 or 7.
// R2: switch bit 19 set closes low-side switch to negative rail.
// R3: power-down mode always forces the low-side switch open.
// R4: standby with standby switch enable 0 keeps switch disabled.
// R5: switch bit 0 keeps switch off; 1 lets the pin sink current.
// R6: threshold bit 18 set compares each result with low and high limits.
// R7: with result buffer disabled no threshold monitoring happens.
// R8: positive select bits 17:13; 10000 temp, 10001 neg rail, 10010 reference.
// R9: codes 11000/11001 select analog regulator halves divided by six.
// R10: codes 11010/11011 select digital regulator halves divided by six.
// R11: codes 10100/10101 select analog supply span halves divided by six.
// R12: code 10111 selects minus half of interface supply span.
// R13: setup-select is three bits at 22:20, eight sets.
// R14: negative select bits 12:8, same code table, resets to 1.
// R15: codes 00000 to 01111 select external inputs 0 to 15.
// R16: fields apply per conversion; writes affect the next one.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ccfd_top
   import ccfd_pkg::*;
#(
   parameter int CHANNELS = CCFD_CHANNELS,
   parameter int RESULT_W = CCFD_CFG_W
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [CCFD_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sequencer side
   input wire logic conv_start,
   input wire logic [$clog2(CHANNELS)-1:0] conv_channel,
   output logic conv_config_valid,
   output logic channel_enabled,
   // converter configuration
   output logic [CCFD_SETUP_W-1:0] setup_select,
   output logic [CCFD_SEL_W-1:0] positive_input_select,
   output logic [CCFD_SEL_W-1:0] negative_input_select,
   output ccfd_src_e positive_source,
   output ccfd_src_e negative_source,
   output logic [3:0] positive_ext_index,
   output logic [3:0] negative_ext_index,
   // low-side switch
   output logic low_side_switch_close,
   // threshold monitor
   input wire logic result_valid,
   input wire logic [RESULT_W-1:0] result_data,
   output logic threshold_active,
   output logic threshold_low_cross,
   output logic threshold_high_cross
);
   localparam int IDX_W = $clog2(CHANNELS);

   typedef enum logic {FETCH_IDLE, FETCH_WAIT} ccfd_fetch_e;

   // maps a select code onto the source it connects
   function automatic ccfd_src_e decode_source(input logic [CCFD_SEL_W-1:0] code);
      ccfd_src_e src;
      src = CCFD_SRC_RESERVED;
      if (!code[4]) begin
         src = CCFD_SRC_EXTERNAL; // [R15]
      end else begin
         case (code)
            CCFD_SEL_TEMP: src = CCFD_SRC_TEMP; // [R8]
            CCFD_SEL_NEG_RAIL: src = CCFD_SRC_NEG_RAIL; // [R8]
            CCFD_SEL_REF: src = CCFD_SRC_REF; // [R8]
            CCFD_SEL_DIG_GND: src = CCFD_SRC_DIG_GND;
            CCFD_SEL_AVDD_P: src = CCFD_SRC_AVDD_P; // [R11]
            CCFD_SEL_AVDD_M: src = CCFD_SRC_AVDD_M; // [R11]
            CCFD_SEL_IO_P: src = CCFD_SRC_IO_P;
            CCFD_SEL_IO_M: src = CCFD_SRC_IO_M; // [R12]
            CCFD_SEL_AREG_P: src = CCFD_SRC_AREG_P; // [R9]
            CCFD_SEL_AREG_M: src = CCFD_SRC_AREG_M; // [R9]
            CCFD_SEL_DREG_P: src = CCFD_SRC_DREG_P; // [R10]
            CCFD_SEL_DREG_M: src = CCFD_SRC_DREG_M; // [R10]
            CCFD_SEL_MV_P: src = CCFD_SRC_MV_P;
            CCFD_SEL_MV_M: src = CCFD_SRC_MV_M;
            default: src = CCFD_SRC_RESERVED;
         endcase
      end
      return src;
   endfunction

   // apb decode
   logic [7:0] idx;
   logic is_chan;
   logic is_mapped;
   logic aligned;
   logic [IDX_W-1:0] chan_idx;
   logic wr_access;
   logic [CCFD_CFG_W-1:0] mem_rd_a;
   logic [CCFD_CFG_W-1:0] mem_rd_b;

   // software registers
   logic [3:0] ctrl;
   logic [RESULT_W-1:0] thr_low;
   logic [RESULT_W-1:0] thr_high;
   logic [3:0] next_ctrl;
   logic [RESULT_W-1:0] next_thr_low;
   logic [RESULT_W-1:0] next_thr_high;

   // per-conversion state
   ccfd_fetch_e fetch_state;
   ccfd_fetch_e next_fetch_state;
   logic [IDX_W-1:0] cur_channel;
   logic [IDX_W-1:0] next_cur_channel;
   logic [CCFD_CFG_W-1:0] cur_cfg;
   logic [CCFD_CFG_W-1:0] next_cur_cfg;
   logic next_conv_config_valid;
   logic next_switch_close;
   logic next_threshold_active;
   logic next_low_cross;
   logic next_high_cross;
   logic [1:0] mode;

   assign idx = {2'h0, paddr[CCFD_ADDR_W-1:2]};
   assign aligned = (paddr[1:0] == 2'h0);
   assign is_chan = aligned && (idx >= CCFD_CHAN_FIRST_IDX) && (idx <= CCFD_CHAN_LAST_IDX);
   assign chan_idx = IDX_W'(idx - CCFD_CHAN_FIRST_IDX);
   assign is_mapped = is_chan || (aligned && ((idx == CCFD_CTRL_IDX) ||
      (idx == CCFD_THR_LOW_IDX) || (idx == CCFD_THR_HIGH_IDX) || (idx == CCFD_STATUS_IDX)));
   // zero wait states: memory read data settle during the setup phase
   assign wr_access = psel && penable && pwrite && is_mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !is_mapped;
   assign mode = ctrl[CCFD_MODE_LSB +: 2];

   ccfd_chan_mem #(
      .DEPTH(CHANNELS),
      .WIDTH(CCFD_CFG_W)
   ) u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_access && is_chan),
      .wr_addr(chan_idx),
      .wr_data(pwdata[CCFD_CFG_W-1:0]),
      .rd_addr_a(chan_idx),
      .rd_data_a(mem_rd_a),
      .rd_addr_b(conv_channel),
      .rd_data_b(mem_rd_b)
   );

   // register read mux, bits above each field read as zero
   always_comb begin
      prdata = 32'h0;
      if (psel && penable && is_mapped) begin
         if (is_chan) begin
            prdata = {8'h0, mem_rd_a};
         end else begin
            case (idx)
               CCFD_CTRL_IDX: prdata = {28'h0, ctrl};
               CCFD_THR_LOW_IDX: prdata = 32'(thr_low);
               CCFD_THR_HIGH_IDX: prdata = 32'(thr_high);
               CCFD_STATUS_IDX: prdata = {21'h0, threshold_active, low_side_switch_close,
                  setup_select, 4'(cur_channel), conv_config_valid, fetch_state == FETCH_WAIT};
               default: prdata = 32'h0;
            endcase
         end
      end
   end

   always_comb begin
      next_ctrl = ctrl;
      next_thr_low = thr_low;
      next_thr_high = thr_high;
      if (wr_access) begin
         case (idx)
            CCFD_CTRL_IDX: next_ctrl = pwdata[3:0];
            CCFD_THR_LOW_IDX: next_thr_low = pwdata[RESULT_W-1:0];
            CCFD_THR_HIGH_IDX: next_thr_high = pwdata[RESULT_W-1:0];
            default: next_ctrl = ctrl;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CCFD_CTRL_RESET;
         thr_low <= '0;
         thr_high <= '1;
      end else begin
         ctrl <= next_ctrl;
         thr_low <= next_thr_low;
         thr_high <= next_thr_high;
      end
   end

   // fetch the channel word one edge after conv_start, then hold it
   always_comb begin
      next_fetch_state = fetch_state;
      next_cur_channel = cur_channel;
      next_cur_cfg = cur_cfg;
      next_conv_config_valid = 1'b0;
      case (fetch_state)
         FETCH_IDLE: begin
            if (conv_start) begin
               next_cur_channel = conv_channel;
               next_fetch_state = FETCH_WAIT;
            end
         end
         FETCH_WAIT: begin
            // a write landing now is already in mem_rd_b only if it came earlier
            next_cur_cfg = mem_rd_b; // [R16]
            next_conv_config_valid = 1'b1;
            next_fetch_state = FETCH_IDLE;
         end
         default: next_fetch_state = FETCH_IDLE;
      endcase
   end

   // switch gating follows the power mode live, not per conversion
   always_comb begin
      next_switch_close = cur_cfg[CCFD_SWITCH_BIT]; // [R2] [R5]
      if (mode == CCFD_MODE_POWER_DOWN) begin
         next_switch_close = 1'b0; // [R3]
      end else if ((mode == CCFD_MODE_STANDBY) && !ctrl[CCFD_STBY_SW_BIT]) begin
         next_switch_close = 1'b0; // [R4]
      end
      next_threshold_active = cur_cfg[CCFD_THR_EN_BIT] && ctrl[CCFD_BUF_EN_BIT]; // [R6] [R7]
      next_low_cross = 1'b0;
      next_high_cross = 1'b0;
      if (result_valid && next_threshold_active) begin
         next_low_cross = (result_data < thr_low); // [R6]
         next_high_cross = (result_data > thr_high); // [R6]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_state <= FETCH_IDLE;
         cur_channel <= '0;
         cur_cfg <= CCFD_CHAN0_RESET;
         conv_config_valid <= 1'b0;
         low_side_switch_close <= 1'b0;
         threshold_active <= 1'b0;
         threshold_low_cross <= 1'b0;
         threshold_high_cross <= 1'b0;
      end else begin
         fetch_state <= next_fetch_state;
         cur_channel <= next_cur_channel;
         cur_cfg <= next_cur_cfg;
         conv_config_valid <= next_conv_config_valid;
         low_side_switch_close <= next_switch_close;
         threshold_active <= next_threshold_active;
         threshold_low_cross <= next_low_cross;
         threshold_high_cross <= next_high_cross;
      end
   end

   // field outputs straight from the held word
   assign channel_enabled = cur_cfg[CCFD_ENABLE_BIT];
   assign setup_select = cur_cfg[CCFD_SETUP_LSB +: CCFD_SETUP_W]; // [R1] [R13]
   assign positive_input_select = cur_cfg[CCFD_POS_LSB +: CCFD_SEL_W]; // [R8]
   assign negative_input_select = cur_cfg[CCFD_NEG_LSB +: CCFD_SEL_W]; // [R14]
   assign positive_source = decode_source(positive_input_select); // [R8]
   assign negative_source = decode_source(negative_input_select); // [R14]
   assign positive_ext_index = positive_input_select[3:0]; // [R15]
   assign negative_ext_index = negative_input_select[3:0];
endmodule
`default_nettype wire

// File: tb/ccfd_chk.sv
// Purpose: port-level checks for the channel field decoder
// Assumes: one clock, ctrl shadowed from APB writes
// Notes: mode gating is live, so it is judged one edge after ctrl
`timescale 1ns/100ps
`default_nettype none
module ccfd_chk
   import ccfd_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [CCFD_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   // conversion
   input wire logic conv_start,
   input wire logic conv_config_valid,
   input wire logic [CCFD_SETUP_W-1:0] setup_select,
   input wire logic [CCFD_SEL_W-1:0] positive_input_select,
   input wire logic [CCFD_SEL_W-1:0] negative_input_select,
   input wire ccfd_src_e positive_source,
   input wire logic [3:0] positive_ext_index,
   // switch and threshold
   input wire logic low_side_switch_close,
   input wire logic result_valid,
   input wire logic threshold_active,
   input wire logic threshold_low_cross,
   input wire logic threshold_high_cross
);
   logic acc;
   logic acc_q;
   logic next_acc_q;
   logic [3:0] ctl;
   logic [3:0] next_ctl;
   // a start right after an accepted one is refused
   assign acc = conv_start & ~acc_q;
   always_comb begin
      next_acc_q = acc;
      next_ctl = ctl;
      if (psel && penable && pwrite && paddr == {CCFD_CTRL_IDX[5:0], 2'h0}) begin
         next_ctl = pwdata[3:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= 1'h0;
         ctl <= CCFD_CTRL_RESET;
      end else begin
         acc_q <= next_acc_q;
         ctl <= next_ctl;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_VALID_LAT: assert property (acc |-> ##2 conv_config_valid)
      else $error("config valid missing after accepted start");
   AST_VALID_CAUSE: assert property (conv_config_valid |-> $past(acc, 2))
      else $error("config valid without accepted start");
   AST_HOLD: assert property (!conv_config_valid |->
      $stable({setup_select, positive_input_select, negative_input_select}))
      else $error("fields changed outside a fetch");
   AST_PD_OPEN: assert property (ctl[1:0] == CCFD_MODE_POWER_DOWN |=> !low_side_switch_close)
      else $error("switch closed in power-down");
   AST_STBY_OFF: assert property (ctl[1:0] == CCFD_MODE_STANDBY && !ctl[2] |=>
      !low_side_switch_close)
      else $error("switch closed in standby without enable");
   AST_NO_THR: assert property (!ctl[3] |=> !threshold_active)
      else $error("threshold active with buffer off");
   AST_CROSS_CAUSE: assert property (threshold_low_cross || threshold_high_cross |->
      $past(result_valid))
      else $error("crossing without a result");
   AST_EXT: assert property (positive_input_select < 5'h10 |->
      positive_source == CCFD_SRC_EXTERNAL && positive_ext_index == positive_input_select[3:0])
      else $error("external input decode wrong");
   AST_TEMP: assert property (positive_input_select == CCFD_SEL_TEMP |->
      positive_source == CCFD_SRC_TEMP)
      else $error("temperature decode wrong");
   AST_DREG: assert property (positive_input_select == CCFD_SEL_DREG_M |->
      positive_source == CCFD_SRC_DREG_M)
      else $error("digital regulator decode wrong");
   cover property (conv_config_valid ##1 low_side_switch_close);
   cover property (threshold_low_cross);
   cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// File: tb/ccfd_top_tb_top.sv
// Purpose: self-checking bench for the channel field decoder
// Assumes: zero-wait APB slave, fixed seed
// Notes: every positive code is swept; refused starts mixed in
`timescale 1ns/100ps
`default_nettype none
module ccfd_top_tb_top
   import ccfd_pkg::*;
;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, conv_start = 1'h0, conv_config_valid, channel_enabled;
   logic [3:0] conv_channel = 4'h0, positive_ext_index, negative_ext_index;
   logic [2:0] setup_select;
   logic [4:0] positive_input_select, negative_input_select;
   ccfd_src_e positive_source, negative_source;
   logic low_side_switch_close, result_valid = 1'h0, threshold_active;
   logic threshold_low_cross, threshold_high_cross;
   logic [23:0] result_data = 24'h0;
   int failures = 0;
   int tests_run = 0;
   always #2.5 pclk = ~pclk;
   ccfd_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_start(conv_start), .conv_channel(conv_channel),
      .conv_config_valid(conv_config_valid), .channel_enabled(channel_enabled),
      .setup_select(setup_select), .positive_input_select(positive_input_select),
      .negative_input_select(negative_input_select), .positive_source(positive_source),
      .negative_source(negative_source), .positive_ext_index(positive_ext_index),
      .negative_ext_index(negative_ext_index), .low_side_switch_close(low_side_switch_close),
      .result_valid(result_valid), .result_data(result_data),
      .threshold_active(threshold_active), .threshold_low_cross(threshold_low_cross),
      .threshold_high_cross(threshold_high_cross)
   );
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize();
      if (failures == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // request held until the edge that sees pready high; data taken at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   function automatic logic [31:0] exp_src(input logic [4:0] c);
      if (c < 5'h10) return CCFD_SRC_EXTERNAL;
      return (c > 5'h1D) ? CCFD_SRC_RESERVED : c - 5'h0F;
   endfunction
   function automatic logic exp_sw(input logic [31:0] w, input logic [31:0] c);
      return w[19] && c[1:0] != 2'h2 && !(c[1:0] == 2'h1 && !c[2]);
   endfunction
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      summarize();
   end
   initial begin
      logic [31:0] r, w, ctl, low, high, rd;
      logic [3:0] ch;
      logic [7:0] a;
      logic e;
      int n;
      void'($urandom(89713));
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, 8'h24, 32'h0, r, e);
      chk("ch0 reset", CCFD_CHAN0_RESET, r);
      apb(1'h0, 8'h28, 32'h0, r, e);
      chk("ch1 reset", CCFD_CHAN_RESET, r);
      apb(1'h0, 8'h04, 32'h0, r, e);
      chk("unmapped err", 32'h1, e);
      low = $urandom % 32'h800000;
      high = low + $urandom % 32'h7FFFFF;
      apb(1'h1, 8'h84, low, r, e);
      apb(1'h1, 8'h88, high, r, e);
      for (int i = 0; i < 32; i++) begin
         ch = 4'($urandom % 16);
         a = 8'((9 + ch) * 4);
         w = $urandom & 32'hFFFFFF;
         w[17:13] = i[4:0];
         if (i < 2) w[22:20] = i[0] ? 3'h7 : 3'h6;
         ctl = $urandom % 16;
         apb(1'h1, a, w, r, e);
         apb(1'h0, a, 32'h0, r, e);
         chk("word", w, r);
         apb(1'h1, 8'h80, ctl, r, e);
         @(posedge pclk);
         conv_start <= 1'h1;
         conv_channel <= ch;
         @(posedge pclk);
         conv_start <= i[0];
         @(posedge pclk);
         conv_start <= 1'h0;
         n = 0;
         while (conv_config_valid !== 1'h1 && n < 10) begin
            @(negedge pclk);
            n++;
         end
         chk("valid", 32'h1, conv_config_valid);
         chk("setup", w[22:20], setup_select);
         chk("pos src", exp_src(w[17:13]), positive_source);
         chk("pos idx", w[16:13], positive_ext_index);
         chk("neg sel", w[12:8], negative_input_select);
         chk("neg src", exp_src(w[12:8]), negative_source);
         chk("neg idx", w[11:8], negative_ext_index);
         chk("enable", w[23], channel_enabled);
         apb(1'h1, a, ~w & 32'hFFFFFF, r, e);
         @(negedge pclk);
         chk("setup hold", w[22:20], setup_select);
         chk("switch", exp_sw(w, ctl), low_side_switch_close);
         chk("thr active", w[18] & ctl[3], threshold_active);
         apb(1'h0, 8'h8C, 32'h0, r, e);
         chk("status", {21'h0, w[18] & ctl[3], exp_sw(w, ctl), w[22:20], ch, 2'h0}, r);
         rd = (i % 4 == 1) ? low : (i % 4 == 2) ? high : $urandom & 32'hFFFFFF;
         @(posedge pclk);
         result_valid <= 1'h1;
         result_data <= rd[23:0];
         @(posedge pclk);
         result_valid <= 1'h0;
         @(negedge pclk);
         chk("low cross", w[18] & ctl[3] & (rd < low), threshold_low_cross);
         chk("high cross", w[18] & ctl[3] & (rd > high), threshold_high_cross);
      end
      summarize();
   end
endmodule
bind ccfd_top ccfd_chk chk_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .conv_start(conv_start),
   .conv_config_valid(conv_config_valid), .setup_select(setup_select),
   .positive_input_select(positive_input_select),
   .negative_input_select(negative_input_select), .positive_source(positive_source),
   .positive_ext_index(positive_ext_index), .low_side_switch_close(low_side_switch_close),
   .result_valid(result_valid), .threshold_active(threshold_active),
   .threshold_low_cross(threshold_low_cross), .threshold_high_cross(threshold_high_cross)
);
`default_nettype wire
